// *** hw/mtc_consts.vh ***
/*
 * Constants of the monitor time-out and gap configuration block:
 * register indices, field positions, reset values and timing figures.
 * Assumes a 50 MHz core clock and a 32-bit APB register port.
 */
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define MTC_CFG_IDX      6'h29
`define MTC_IRQ_STAT_IDX 6'h2A
`define MTC_IRQ_MASK_IDX 6'h2B

// ****************************************************************
// Configuration fields
// ****************************************************************
`define MTC_TOSEL_HI     15
`define MTC_TOSEL_LO     14
`define MTC_RSV13_BIT    13
`define MTC_GAP_BIT      12
`define MTC_CFG_RESET    16'h0800
`define MTC_CFG_RMASK    16'hDFFF

// ****************************************************************
// Interrupt bits
// ****************************************************************
`define MTC_IRQ_W        2
`define MTC_IRQ_TO       0
`define MTC_IRQ_FMT      1

// ****************************************************************
// Timing
// ****************************************************************
`define MTC_CLK_NS       20
`define MTC_US_NS        1000
`define MTC_US_CYC       (`MTC_US_NS / `MTC_CLK_NS)
`define MTC_TO_US_0      8'd18
`define MTC_TO_US_1      8'd23
`define MTC_TO_US_2      8'd82
`define MTC_TO_US_3      8'd140
`define MTC_RTRT_US_0    8'd61
`define MTC_RTRT_US_1    8'd66
`define MTC_RTRT_US_2    8'd122
`define MTC_RTRT_US_3    8'd180
`define MTC_GAP_MIN_NS   4000
`define MTC_GAP_MIN_CYC  ((`MTC_GAP_MIN_NS + `MTC_CLK_NS - 1) / `MTC_CLK_NS)

`endif

// *** hw/mtc_tick_div.v ***
/*
 * Microsecond tick divider for the time-out counter.
 * Assumes one core clock; clear_i restarts the phase so that
 * the first tick lands exactly DIV cycles after the clear.
 */
`timescale 1ns/1ps

module mtc_tick_div
#(
    parameter DIV = 50
)
(
    // Clock and reset
    input  wire       core_clk_i,
    input  wire       reset_n_i,
    // Control
    input  wire       clear_i,
    // Tick
    output wire       tick_o
);

    reg  [7:0] cnt_reg;
    wire       wrap;

    assign wrap   = (cnt_reg == DIV[7:0] - 8'h01);
    assign tick_o = wrap & ~clear_i;

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i || clear_i || wrap)
        begin
            cnt_reg <= 8'h00;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

endmodule

// *** hw/mtc_monitor_cfg.v ***
/*
 * Bus monitor time-out and gap configuration: APB register bank with
 * the no-response timer, the minimum gap checker and an interrupt.
 * Assumes the word decoder gives one-cycle pulses at mid-parity and
 * mid-sync of each word, synchronous to core_clk_i.
 */
// How it works
// RQ1: Two-bit select picks 18, 23, 82 or 140 us; resets to zero.
// RQ2: Normal time-out runs from command mid-parity to status mid-sync.
// RQ3: RT-to-RT uses 61, 66, 122 or 180 us to first data mid-sync.
// RQ4: Gap check on requires 4 us gap before messages and responses.
// RQ5: A short gap with checking on flags a format error.
// RQ6: Gap check off, its reset value, disables the short gap check.
// RQ7: Software keeps reserved bits 13, 11, 10 at reset; no effect.
`timescale 1ns/1ps
`include "mtc_consts.vh"

module mtc_monitor_cfg
#(
    parameter US_CYC  = `MTC_US_CYC,
    parameter GAP_CYC = `MTC_GAP_MIN_CYC
)
(
    // Clock and reset
    input  wire        core_clk_i,
    input  wire        reset_n_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // Word decoder events
    input  wire        cmd_parity_i,
    input  wire        rt_rt_i,
    input  wire        word_parity_i,
    input  wire        word_sync_i,
    input  wire        gap_point_i,
    // Settings and results
    output wire [1:0]  monitor_timeout_select_o,
    output wire        gap_check_enable_o,
    output reg         no_response_o,
    output reg         format_error_o,
    output wire        irq_o
);

    // ****************************************************************
    // Register decode
    // ****************************************************************
    reg  [15:0]             cfg_reg;
    reg  [`MTC_IRQ_W-1:0]   stat_reg;
    reg  [`MTC_IRQ_W-1:0]   mask_reg;
    wire                    access;
    wire                    wr;
    wire                    hit_cfg;
    wire                    hit_stat;
    wire                    hit_mask;
    wire                    mapped;

    assign access   = psel_i & penable_i;
    assign hit_cfg  = (paddr_i[7:2] == `MTC_CFG_IDX);
    assign hit_stat = (paddr_i[7:2] == `MTC_IRQ_STAT_IDX);
    assign hit_mask = (paddr_i[7:2] == `MTC_IRQ_MASK_IDX);
    assign mapped   = (hit_cfg | hit_stat | hit_mask)
                      & (paddr_i[1:0] == 2'b00);
    assign wr       = access & pwrite_i & mapped;
    // Zero wait states; unmapped or unaligned gets an error
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~mapped;

    always @*
    begin
        prdata_o = 32'h0000_0000;
        if (hit_cfg)
        begin
            // Write-only bit 13 reads as zero
            prdata_o[15:0] = cfg_reg & `MTC_CFG_RMASK;
        end
        else if (hit_stat)
        begin
            prdata_o[`MTC_IRQ_W-1:0] = stat_reg;
        end
        else if (hit_mask)
        begin
            prdata_o[`MTC_IRQ_W-1:0] = mask_reg;
        end
        if (!mapped)
        begin
            prdata_o = 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            cfg_reg <= `MTC_CFG_RESET; // RQ1 RQ6
        end
        else if (wr && hit_cfg)
        begin
            // Reserved bits are stored but steer nothing
            cfg_reg <= pwdata_i[15:0]; // RQ7
        end
    end

    assign monitor_timeout_select_o = cfg_reg[`MTC_TOSEL_HI:`MTC_TOSEL_LO];
    assign gap_check_enable_o       = cfg_reg[`MTC_GAP_BIT];

    // ****************************************************************
    // No-response timer
    // ****************************************************************
    reg        wait_reg;
    reg        rtrt_reg;
    reg  [7:0] us_reg;
    reg  [7:0] limit;
    wire       tick;

    mtc_tick_div
    #(
        .DIV        (US_CYC)
    )
    u_tick
    (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clear_i    (cmd_parity_i),
        .tick_o     (tick)
    );

    always @*
    begin
        case ({rtrt_reg, monitor_timeout_select_o})
            3'b000:  limit = `MTC_TO_US_0; // RQ1
            3'b001:  limit = `MTC_TO_US_1; // RQ1
            3'b010:  limit = `MTC_TO_US_2; // RQ1
            3'b011:  limit = `MTC_TO_US_3; // RQ1
            3'b100:  limit = `MTC_RTRT_US_0; // RQ3
            3'b101:  limit = `MTC_RTRT_US_1; // RQ3
            3'b110:  limit = `MTC_RTRT_US_2; // RQ3
            3'b111:  limit = `MTC_RTRT_US_3; // RQ3
            default: limit = `MTC_TO_US_0;
        endcase
    end

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            wait_reg      <= 1'b0;
            rtrt_reg      <= 1'b0;
            us_reg        <= 8'h00;
            no_response_o <= 1'b0;
        end
        else
        begin
            no_response_o <= 1'b0;
            if (cmd_parity_i)
            begin
                // Start at mid-parity of the command
                wait_reg <= 1'b1; // RQ2
                rtrt_reg <= rt_rt_i; // RQ3
                us_reg   <= 8'h00;
            end
            else if (wait_reg && word_sync_i)
            begin
                // Reply mid-sync stops the timer; wins over a tick
                wait_reg <= 1'b0; // RQ2 RQ3
            end
            else if (wait_reg && tick)
            begin
                us_reg <= us_reg + 8'h01;
                if (us_reg + 8'h01 == limit)
                begin
                    wait_reg      <= 1'b0;
                    no_response_o <= 1'b1; // RQ1 RQ3
                end
            end
        end
    end

    // ****************************************************************
    // Minimum gap checker
    // ****************************************************************
    reg  [8:0] gap_reg;
    reg        gap_seen_reg;
    wire       gap_short;

    assign gap_short = gap_seen_reg && (gap_reg < GAP_CYC[8:0]);

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            gap_reg        <= 9'h000;
            gap_seen_reg   <= 1'b0;
            format_error_o <= 1'b0;
        end
        else
        begin
            format_error_o <= 1'b0;
            if (word_parity_i)
            begin
                gap_reg      <= 9'h001;
                gap_seen_reg <= 1'b1;
            end
            else if (gap_reg < GAP_CYC[8:0])
            begin
                // Saturates so long idle never wraps to short
                gap_reg <= gap_reg + 9'h001;
            end
            if (word_sync_i && gap_point_i && gap_short
                && gap_check_enable_o) // RQ4 RQ6
            begin
                format_error_o <= 1'b1; // RQ5
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************
    wire [`MTC_IRQ_W-1:0] events;

    assign events[`MTC_IRQ_TO]  = no_response_o;
    assign events[`MTC_IRQ_FMT] = format_error_o;
    assign irq_o = |(stat_reg & mask_reg);

    always @(posedge core_clk_i)
    begin
        if (!reset_n_i)
        begin
            stat_reg <= {`MTC_IRQ_W{1'b0}};
            mask_reg <= {`MTC_IRQ_W{1'b0}};
        end
        else
        begin
            // New event beats a same-cycle write-one clear
            if (wr && hit_stat)
            begin
                stat_reg <= (stat_reg & ~pwdata_i[`MTC_IRQ_W-1:0])
                            | events;
            end
            else
            begin
                stat_reg <= stat_reg | events;
            end
            if (wr && hit_mask)
            begin
                mask_reg <= pwdata_i[`MTC_IRQ_W-1:0];
            end
        end
    end

endmodule

// *** test/mtc_monitor_cfg_assertions.sv ***
/* Checker for mtc_monitor_cfg.
   Assumes one core clock and the sync active-low reset. */
`timescale 1ns/1ps

module mtc_cfg_checker
#(
    parameter US_CYC  = 50,
    parameter GAP_CYC = 200
)
(
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       reset_n_i,
    // Word events
    input wire logic       cmd_parity_i,
    input wire logic       rt_rt_i,
    input wire logic       word_sync_i,
    input wire logic       gap_point_i,
    // Results
    input wire logic [1:0] monitor_timeout_select_o,
    input wire logic       gap_check_enable_o,
    input wire logic       no_response_o,
    input wire logic       format_error_o
);
// ********
// Properties
// ********
default clocking cb @(posedge core_clk_i); endclocking
default disable iff (!reset_n_i);
// Cycles since the last arming command, and its captured mode
int   since_cmd = 0;
logic rt_cap    = 1'b0;
int   lim_us;
always @(posedge core_clk_i)
begin
    if (cmd_parity_i)
    begin
        since_cmd <= 1;
        rt_cap    <= rt_rt_i;
    end
    else if (since_cmd < 1000000)
    begin
        since_cmd <= since_cmd + 1;
    end
end
always @*
begin
    case ({rt_cap, monitor_timeout_select_o})
        3'b000:  lim_us = 18;
        3'b001:  lim_us = 23;
        3'b010:  lim_us = 82;
        3'b011:  lim_us = 140;
        3'b100:  lim_us = 61;
        3'b101:  lim_us = 66;
        3'b110:  lim_us = 122;
        default: lim_us = 180;
    endcase
end
a_timeout_len: assert property (no_response_o |->
    since_cmd == lim_us * US_CYC + 1) else $error("time-out length wrong");
// Shortest time-out is far beyond this
sequence s_quiet;
    !no_response_o [*7];
endsequence
a_sel_reset: assert property ($rose(reset_n_i) |->
    monitor_timeout_select_o == 2'b00) else $error("select not reset");
a_arm_quiet: assert property (cmd_parity_i |-> ##2 s_quiet)
    else $error("early time-out");
a_sync_stop: assert property (word_sync_i |=> !no_response_o)
    else $error("time-out after sync");
a_resp_pulse: assert property (no_response_o |=> !no_response_o)
    else $error("time-out pulse too long");
a_gap_reset: assert property ($rose(reset_n_i) |->
    !gap_check_enable_o) else $error("gap check not reset");
a_gap_off: assert property (!gap_check_enable_o |=> !format_error_o)
    else $error("format error with check off");
a_fmt_cause: assert property (format_error_o |->
    $past(word_sync_i && gap_point_i && gap_check_enable_o))
    else $error("format error without checked sync");
endmodule

bind mtc_monitor_cfg mtc_cfg_checker #(.US_CYC(US_CYC), .GAP_CYC(GAP_CYC))
    u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .cmd_parity_i(cmd_parity_i), .rt_rt_i(rt_rt_i),
    .word_sync_i(word_sync_i),
    .gap_point_i(gap_point_i),
    .monitor_timeout_select_o(monitor_timeout_select_o),
    .gap_check_enable_o(gap_check_enable_o),
    .no_response_o(no_response_o), .format_error_o(format_error_o));

// *** test/mtc_bus_model.sv ***
/* Bus traffic model: word decoder pulses of the observed bus.
   Assumes tasks are called just after a rising edge. */
`timescale 1ns/1ps

module mtc_bus_model
(
    // Clock
    input  wire core_clk_i,
    // Word events
    output reg  cmd_parity_o  = 1'b0,
    output reg  rt_rt_o       = 1'b0,
    output reg  word_parity_o = 1'b0,
    output reg  word_sync_o   = 1'b0,
    output reg  gap_point_o   = 1'b0
);
// ********
// Traffic
// ********
task cmd(input r);
    @(posedge core_clk_i);
    cmd_parity_o <= 1'b1;
    rt_rt_o      <= r;
    @(posedge core_clk_i);
    cmd_parity_o <= 1'b0;
    rt_rt_o      <= ~r;
endtask
// Sync lands d cycles after the last strobe; level inverted when idle
task sync(input int d, input g);
    repeat (d - 1) @(posedge core_clk_i);
    word_sync_o <= 1'b1;
    gap_point_o <= g;
    @(posedge core_clk_i);
    word_sync_o <= 1'b0;
    gap_point_o <= ~g;
endtask
task word(input int d, input g);
    @(posedge core_clk_i);
    word_parity_o <= 1'b1;
    @(posedge core_clk_i);
    word_parity_o <= 1'b0;
    sync(d, g);
endtask
endmodule

// *** test/mtc_monitor_cfg_bench.sv ***
/* Self-checking bench for mtc_monitor_cfg over APB.
   Assumes mtc_bus_model drives the word events. */
`timescale 1ns/1ps
`include "mtc_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end

module mtc_monitor_cfg_bench;
localparam       US  = 5;
localparam       GAP = 20;
localparam [7:0] CFG = {`MTC_CFG_IDX, 2'b00};
localparam [7:0] ST  = {`MTC_IRQ_STAT_IDX, 2'b00};
localparam [7:0] MK  = {`MTC_IRQ_MASK_IDX, 2'b00};
reg        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err;
reg [7:0]  paddr = 0;
reg [31:0] pwdata = 0, rd, w;
wire [31:0] prdata;
wire [1:0]  sel;
wire        pready, pslverr, cp, rt, wp, ws, gp, nr, fe, irq, gen;
int fails = 0, compares = 0, seed = 32'h33BA7843, k, i, j;
int nr_cnt = 0, fe_cnt = 0;
int us[8] = '{18, 61, 23, 66, 82, 122, 140, 180};
mtc_monitor_cfg #(.US_CYC(US), .GAP_CYC(GAP)) DUT (.core_clk_i(clk),
    .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cmd_parity_i(cp), .rt_rt_i(rt), .word_parity_i(wp),
    .word_sync_i(ws), .gap_point_i(gp), .monitor_timeout_select_o(sel),
    .gap_check_enable_o(gen), .no_response_o(nr), .format_error_o(fe),
    .irq_o(irq));
mtc_bus_model BUS (.core_clk_i(clk), .cmd_parity_o(cp), .rt_rt_o(rt),
    .word_parity_o(wp), .word_sync_o(ws), .gap_point_o(gp));
// ********
// Clock, counters, tasks
// ********
initial forever #10 clk = ~clk;
always @(posedge clk)
begin
    nr_cnt <= nr_cnt + nr;
    fe_cnt <= fe_cnt + fe;
end
task stop_test;
    if (fails == 0 && compares > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
// Idle edge at the end keeps psel from being set twice in one step
task apb(input wr, input [7:0] a, input [31:0] d);
    psel   <= 1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
    @(posedge clk);
endtask
// ********
// Scenarios
// ********
initial
begin
    repeat (20) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    apb(0, CFG, 0);
    `CHK("cfg", 32'h0800, rd)
    `CHK("gap", 1'b0, gen)
    apb(0, 8'hB0, 0);
    `CHK("unmapped", 1'b1, err)
    `CHK("ready", 1'b1, pready)
    repeat (4)
    begin
        // Reserved bits kept at their reset values by software
        w = ($random(seed) & 32'h0000_D3FF) | 32'h0000_0800;
        apb(1, CFG, w);
        apb(0, CFG, 0);
        `CHK("cfg", w & 32'h0000_DFFF, rd)
        `CHK("sel", w[15:14], sel)
    end
    for (i = 0; i < 8; i++)
    begin
        apb(1, CFG, (i >> 1) << 14 | 32'h0800);
        apb(1, MK, i & 1);
        BUS.cmd(i & 1);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (nr !== 1'b1 && k < 2000);
        `CHK("timeout", us[i] * US + 1, k)
        @(posedge clk);
        `CHK("irq", i & 1, irq)
        apb(0, ST, 0);
        `CHK("status", 1, rd)
        apb(1, ST, 3);
        `CHK("irq", 0, irq)
    end
    BUS.cmd(0);
    k = nr_cnt;
    BUS.sync(us[6] * US, 0);
    repeat (40) @(posedge clk);
    `CHK("cancel", k, nr_cnt)
    apb(1, CFG, 32'h1800);
    for (j = 0; j < 4; j++)
    begin
        if (j == 3)
            apb(1, CFG, 32'h0800);
        k = fe_cnt;
        BUS.word(GAP - 1 + (j == 1), j != 2);
        repeat (2) @(posedge clk);
        `CHK("format", k + (j == 0), fe_cnt)
    end
    apb(0, ST, 0);
    `CHK("status", 2, rd)
    stop_test;
end
// Run needs about 4500 cycles; this allows over four times that
initial
begin
    #400000;
    fails++;
    stop_test;
end
endmodule
